// ===== dv/eep_master.sv
// Two-wire bus master model: drives SCL, pulls SDA low when asked.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`default_nettype none
module eep_master (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic bitx(input logic b, output logic r);
      #200 pull = ~b;
      #1150 scl = 1'b1;
      #650 r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      #200 pull = 1'b0;
      #200 scl = 1'b1;
      #650 pull = 1'b1;
      #650 scl = 1'b0;
   endtask
   task automatic stop();
      #200 pull = 1'b1;
      #1150 scl = 1'b1;
      #650 pull = 1'b0;
      #650;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
      end
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, d[i]);
      end
      bitx(last, r);
   endtask
endmodule
`default_nettype wire

// ===== dv/eep_slave_bench.sv
// Bench for the two-wire EEPROM slave: write, read and protect sequences.
// Assumes the master model in eep_master.sv and a pulled-up SDA.
`default_nettype none
module eep_slave_bench
   import eep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WRC = 3000;
   logic clk, sys_rst, sda_o, sda_oe, busy, rps, pps, wp_i, scl, pull, k;
   logic [2:0] st;
   logic [7:0] dw;
   int mismatches = 0;
   int comparisons = 0;
   wire sda = ~((sda_oe & ~sda_o) | pull);
   assign dw = {MEM_CODE, st, 1'b0};
   eep_master m (.scl(scl), .pull(pull), .sda(sda));
   eep_slave #(.WR_CYC(WRC)) DUT (.clk(clk), .sys_rst(sys_rst), .scl_clk(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .slave_addr_strap_0(st[0]),
      .slave_addr_strap_1(st[1]), .slave_addr_strap_2(st[2]), .wp_i(wp_i),
      .busy(busy), .reversible_protect_state(rps), .perm_protect_state(pps));
   function automatic logic [7:0] pc(input logic [2:0] c);
      return {PROT_CODE, c, 1'b0};
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic [7:0] b0, b1, b2, input logic [2:0] ea);
      logic [2:0] a;
      m.start();
      m.wbyte(b0, a[2]);
      m.wbyte(b1, a[1]);
      m.wbyte(b2, a[0]);
      m.stop();
      chk({5'h0, a}, {5'h0, ea});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      m.start();
      m.wbyte(dw, k);
      m.wbyte(a, k);
      m.start();
      m.wbyte(dw | 8'h01, k);
      m.rbyte(d, 1'b1);
      m.stop();
      chk(d, e);
   endtask
   // Bounded wait for the write cycle to finish
   task automatic wtb();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < WRC + 8) begin
         @(negedge clk);
         n++;
      end
      chk({7'h0, busy}, 8'h00);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #900000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      // Reset rises after time zero so the link flops see a clean edge
      sys_rst = 1'b0;
      wp_i = 1'b0;
      st = 3'h0;
      #1 sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (10) @(negedge clk);
      xfer(dw, 8'h85, 8'h5a, 3'h7);
      chk({7'h0, busy}, 8'h01);
      m.start();
      m.wbyte(dw, k);
      m.stop();
      chk({7'h0, k}, 8'h00);
      wtb();
      rd(8'h85, 8'h5a);
      @(negedge clk) st = 3'h5;
      xfer({MEM_CODE, 3'h0, 1'b0}, 8'h00, 8'h00, 3'h0);
      @(negedge clk) wp_i = 1'b1;
      xfer(dw, 8'h10, 8'h33, 3'h6);
      chk({7'h0, busy}, 8'h00);
      xfer(pc(CMD_SWP), 8'h00, 8'h00, 3'h6);
      chk({7'h0, rps}, 8'h00);
      rd(8'h10, 8'hff);
      @(negedge clk) wp_i = 1'b0;
      xfer(pc(CMD_SWP), 8'h00, 8'h00, 3'h7);
      wtb();
      chk({7'h0, rps}, 8'h01);
      xfer(dw, 8'h20, 8'h44, 3'h6);
      xfer(pc(CMD_CWP), 8'h20, 8'h00, 3'h7);
      wtb();
      chk({7'h0, rps}, 8'h00);
      m.start();
      m.wbyte(dw | 8'h01, k);
      chk({7'h0, k}, 8'h01);
      repeat (3) m.bitx(1'b1, k);
      m.stop();
      chk({6'h0, sda_oe, sda_o}, 8'h00);
      xfer(pc(3'h5), 8'h00, 8'h00, 3'h7);
      wtb();
      chk({7'h0, pps}, 8'h01);
      xfer(pc(CMD_CWP), 8'h00, 8'h00, 3'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== hdl/eep_pkg.sv
// Constants and types for the two-wire EEPROM slave.
// Assumes a 125 MHz core clock.
`default_nettype none
package eep_pkg;
   localparam logic [3:0] MEM_CODE = 4'ha;
   localparam logic [3:0] PROT_CODE = 4'h6;
   localparam logic [2:0] CMD_SWP = 3'h1;
   localparam logic [2:0] CMD_CWP = 3'h3;
   localparam logic [7:0] LOWER_LIMIT = 8'h80;
   localparam logic [7:0] ERASED = 8'hff;
   localparam int MEM_DEPTH = 256;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam real CLK_NS = 8.0;
   localparam real T_WR_MS = 5.0;
   localparam int WR_CYC_DEF = int'($floor(T_WR_MS * 1.0e6 / CLK_NS));
   localparam int BUSY_W = 20;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_WADR, ST_DATA, ST_DONE, ST_RD, ST_SKIP
   } eep_st_t;

   typedef enum logic [1:0] {K_SWP, K_CWP, K_SET_PERMANENT_PROTECT_CMD} eep_kind_t;

   typedef struct packed {
      logic tog;
      logic sbit;
   } eep_link_t;

   typedef struct packed {
      eep_st_t st;
      eep_kind_t kind;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] wadr;
      logic [7:0] wdat;
      logic [7:0] ptr;
      logic ack;
      logic arm;
      logic cmd;
      logic busy;
      logic [BUSY_W-1:0] bcnt;
      logic oe;
      logic sdo;
      logic scl_a, scl_b, scl_p;
      logic sda_a, sda_b, sda_p;
      logic tg_a, tg_b, tg_p;
      logic wp_a, wp_b;
      logic [2:0] sa_a, sa_b;
   } eep_core_t;
endpackage
`default_nettype wire

// ===== hdl/eep_slave.sv
// Two-wire EEPROM slave: byte write, current read, write protect.
// Assumes SDA is open drain with an external pull-up and that
// SCL high and low phases each last many core clock periods.
//
// What this block does
// R1 - Detect start: SDA falls, SCL high
// R2 - Master opens every operation with start
// R3 - Detect stop: SDA rises, SCL high
// R4 - Stop during read aborts, releases SDA
// R5 - Stop during write starts write cycle
// R6 - SDA changes only while SCL low
// R7 - SDA change with SCL high never data
// R8 - Receiver acknowledges on ninth clock
// R9 - Busy write cycle: ignore, never acknowledge
// R10 - Address is 1010, strap bits, R/W
// R11 - Acknowledge only on strap match; SWP and CWP protect codes are acked without one, except SWP while reversible protect is set
// R12 - Open strap pin reads as low
// R13 - Write address acked, word address acked
// R14 - Data byte acked, stop programs it
// R15 - Protect pin high blocks all writes
// R16 - Master keeps protect pin steady
// R17 - Protect pin high blocks protect commands
// R18 - Under protect, address acked, data not
// R19 - Soft protect blocks 00h to 7Fh
// R20 - Array starts all FFh
// R21 - Reset at power-on before any start
// R22 - Code 0110 unanswered once permanent
// R23 - Reversible kept until cleared; permanent forever
// R24 - Write cycle ends within 5 ms
// R25 - 256 bytes addressed by word address
`default_nettype none
module eep_slave
   import eep_pkg::*;
#(
   parameter int WR_CYC = WR_CYC_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic slave_addr_strap_0,
   input wire logic slave_addr_strap_1,
   input wire logic slave_addr_strap_2,
   input wire logic wp_i,
   output logic busy,
   output logic reversible_protect_state,
   output logic perm_protect_state
);
   eep_link_t lk_q;
   eep_core_t q, d;
   logic ev, fall, start, stop, do_wr;
   logic hit_mem, hit_cmd, wr_ok;
   logic [7:0] bin, rbyte;
   logic [7:0] mem_q [MEM_DEPTH];
   logic reversible_protect_state_q = 1'b0;
   logic perm_q = 1'b0;

   // Nonvolatile array delivered erased
   initial begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
         mem_q[i] = ERASED; // R20
      end
   end

   // Link side: take SDA on each SCL rise, flag it by a toggle
   always_ff @(posedge scl_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_q <= '0;
      end else begin
         lk_q.tog <= ~lk_q.tog;
         lk_q.sbit <= sda_i;
      end
   end

   always_comb begin
      d = q;
      do_wr = 1'b0;
      hit_mem = 1'b0;
      hit_cmd = 1'b0;
      wr_ok = 1'b0;
      d.scl_a = scl_clk;
      d.scl_b = q.scl_a;
      d.scl_p = q.scl_b;
      d.sda_a = sda_i;
      d.sda_b = q.sda_a;
      d.sda_p = q.sda_b;
      d.tg_a = lk_q.tog;
      d.tg_b = q.tg_a;
      d.tg_p = q.tg_b;
      d.wp_a = wp_i;
      d.wp_b = q.wp_a;
      // Open straps read low through pad pull-downs
      d.sa_a = {slave_addr_strap_2, slave_addr_strap_1, slave_addr_strap_0}; // R12
      d.sa_b = q.sa_a;
      // Sampled bit is held by the link side until the next SCL rise
      ev = q.tg_b ^ q.tg_p;
      fall = q.scl_p & ~q.scl_b;
      start = q.scl_b & q.scl_p & q.sda_p & ~q.sda_b; // R1
      stop = q.scl_b & q.scl_p & ~q.sda_p & q.sda_b; // R3
      bin = {q.sh[6:0], lk_q.sbit};
      rbyte = mem_q[q.ptr];
      if (q.busy) begin
         if (q.bcnt == BUSY_W'(WR_CYC - 1)) begin
            d.busy = 1'b0; // R24
            d.bcnt = '0;
         end else begin
            d.bcnt = q.bcnt + 1'b1;
         end
      end
      if (start) begin
         // Only a start leads to address decode
         d.st = q.busy ? ST_SKIP : ST_ADDR; // R2 R7 R9
         d.cnt = '0;
         d.ack = 1'b0;
         d.arm = 1'b0;
      end else if (stop) begin
         if (q.arm && !q.busy) begin
            do_wr = 1'b1; // R5
            d.busy = 1'b1;
            d.bcnt = '0;
         end
         d.st = ST_IDLE; // R4
         d.oe = 1'b0; // R4
         d.arm = 1'b0;
         d.cnt = '0;
      end else if (ev && q.st != ST_IDLE) begin
         if (q.cnt == BIT_ACK) begin
            d.cnt = '0;
            // After a data byte the master answers; the address ack is ours
            if (q.st == ST_RD && !q.ack) begin
               d.ptr = q.ptr + 1'b1;
               if (lk_q.sbit) begin
                  d.st = ST_SKIP;
               end
            end
         end else begin
            d.sh = bin;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == BIT_LAST) begin
               d.ack = 1'b0;
               unique case (q.st)
                  ST_ADDR: begin
                     hit_mem = bin[7:4] == MEM_CODE && bin[3:1] == q.sa_b; // R10 R11
                     hit_cmd = bin[7:4] == PROT_CODE && !perm_q // R22
                        && !(reversible_protect_state_q && bin[3:1] == CMD_SWP)
                        && (bin[3:1] == CMD_SWP || bin[3:1] == CMD_CWP
                           || bin[3:1] == q.sa_b);
                     d.cmd = bin[7:4] == PROT_CODE;
                     d.kind = bin[3:1] == CMD_SWP ? K_SWP
                        : bin[3:1] == CMD_CWP ? K_CWP : K_SET_PERMANENT_PROTECT_CMD;
                     d.ack = (hit_mem | hit_cmd) & ~q.busy; // R9 R11
                     if (!d.ack) begin
                        d.st = ST_SKIP;
                     end else if (bin[0]) begin
                        d.st = hit_mem ? ST_RD : ST_SKIP;
                     end else begin
                        d.st = ST_WADR; // R13
                     end
                  end
                  ST_WADR: begin
                     d.ack = 1'b1; // R13
                     d.wadr = bin;
                     d.st = ST_DATA;
                     if (!q.cmd) begin
                        d.ptr = bin;
                     end
                  end
                  ST_DATA: begin
                     // Protect pin taken once, at the data byte
                     wr_ok = !q.wp_b && (q.cmd || // R15 R16 R17
                        !((reversible_protect_state_q | perm_q) && q.wadr < LOWER_LIMIT)); // R19
                     d.wdat = bin;
                     d.ack = wr_ok; // R14 R18
                     d.arm = wr_ok;
                     d.st = ST_DONE;
                  end
                  ST_IDLE, ST_DONE, ST_RD, ST_SKIP: begin
                  end
               endcase
            end
         end
      end
      // SDA moves only just after SCL falls
      if (fall) begin
         if (q.cnt == BIT_ACK) begin
            // Ack is clear after a read data byte, so SDA is left to the master
            d.oe = q.ack; // R8 R6
         end else if (q.st == ST_RD) begin
            d.oe = ~rbyte[~q.cnt[2:0]]; // R6
         end else begin
            d.oe = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0; // R21
      end else begin
         q <= d;
      end
   end

   // Array and protect state are not cleared by reset
   always @(posedge clk) begin
      if (do_wr) begin
         if (!q.cmd) begin
            mem_q[q.wadr] <= q.wdat; // R14 R25
         end else if (q.kind == K_SWP) begin
            reversible_protect_state_q <= 1'b1; // R23
         end else if (q.kind == K_CWP) begin
            reversible_protect_state_q <= 1'b0; // R23
         end else begin
            perm_q <= 1'b1; // R23
         end
      end
   end

   // Open drain: the pad only ever pulls low
   assign sda_o = q.sdo;
   assign sda_oe = q.oe;
   assign busy = q.busy;
   assign reversible_protect_state = reversible_protect_state_q;
   assign perm_protect_state = perm_q;

   // Checks run on the core clock and sleep during reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_busy_quiet;
      q.busy && !fall |=> !q.oe || q.st == ST_RD;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy"); // R9

   property p_busy_addr;
      q.busy && ev && q.cnt == BIT_LAST |=> !q.ack;
   endproperty
   a_busy_addr: assert property (p_busy_addr) else $error("ack while busy"); // R9

   property p_start;
      start |=> q.cnt == 4'h0 && (q.st == ST_ADDR || q.st == ST_SKIP);
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // R1

   property p_stop_rel;
      stop |=> !q.oe && q.st == ST_IDLE ##1 !q.oe;
   endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("stop left SDA driven"); // R4

   property p_stop_wr;
      stop && q.arm && !q.busy |=> q.busy && q.bcnt == '0;
   endproperty
   a_stop_wr: assert property (p_stop_wr) else $error("write cycle not started"); // R5

   property p_stable;
      q.scl_b && !fall |=> $stable(q.oe) || $past(stop);
   endproperty
   a_stable: assert property (p_stable) else $error("SDA moved with SCL high"); // R6

   property p_miss;
      ev && q.st == ST_ADDR && q.cnt == BIT_LAST && bin[7:4] == MEM_CODE
         && bin[3:1] != q.sa_b |=> !q.ack;
   endproperty
   a_miss: assert property (p_miss) else $error("ack on foreign address"); // R11

   property p_ack9;
      fall && q.cnt == BIT_ACK && q.ack |=> q.oe;
   endproperty
   a_ack9: assert property (p_ack9) else $error("ack missing"); // R8

   property p_wp;
      ev && q.st == ST_DATA && q.cnt == BIT_LAST && q.wp_b |=> !q.ack && !q.arm;
   endproperty
   a_wp: assert property (p_wp) else $error("write under protect pin"); // R15

   property p_low;
      ev && q.st == ST_DATA && q.cnt == BIT_LAST && !q.cmd && reversible_protect_state_q
         && q.wadr < LOWER_LIMIT |=> !q.arm;
   endproperty
   a_low: assert property (p_low) else $error("soft protect ignored"); // R19

   property p_perm;
      perm_q && ev && q.st == ST_ADDR && q.cnt == BIT_LAST
         && bin[7:4] == PROT_CODE |=> !q.ack;
   endproperty
   a_perm: assert property (p_perm) else $error("protect code answered"); // R22

   property p_bcnt;
      q.busy |-> q.bcnt < BUSY_W'(WR_CYC);
   endproperty
   a_bcnt: assert property (p_bcnt) else $error("write cycle overran"); // R24

   // Main scenarios
   c_write: cover property (stop && q.arm && !q.cmd);
   c_read: cover property (q.st == ST_RD && fall);
   c_cmd: cover property (stop && q.arm && q.cmd);
   c_busy_nack: cover property (q.busy && start);
endmodule
`default_nettype wire
